// ==== design/ecc_monitor_pkg.sv ====
// constants and carrier types for the memory check-bit fault monitor
package ecc_monitor_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [15:0] CODE_CHECK_CONFIG_IDX = 16'hA00D;
	localparam logic [15:0] CODE_FAULT_ADDR_LOW_IDX = 16'hA00E;
	localparam logic [15:0] CODE_FAULT_ADDR_HIGH_IDX = 16'hA00F;
	localparam logic [15:0] SRAM_CHECK_CONFIG_IDX = 16'hA02D;
	localparam logic [15:0] SRAM_FAULT_ADDR_LOW_IDX = 16'hA02E;
	localparam logic [15:0] SRAM_FAULT_ADDR_HIGH_IDX = 16'hA02F;
	localparam logic [15:0] RESET_CONTROL_IDX = 16'hA010;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CFG_ENABLE_BIT = 7;
	localparam int CFG_FATAL_IRQ_EN_BIT = 5;
	localparam int CFG_FIXED_IRQ_EN_BIT = 4;
	localparam int CFG_FATAL_FLAG_BIT = 1;
	localparam int CFG_FIXED_FLAG_BIT = 0;
	localparam int RST_FATAL_RESET_EN_BIT = 6;
	localparam int RST_FLAG_CLEAR_BIT = 4;
	localparam int RST_CHECK_ERR_FLAG_BIT = 2;
	localparam int CODE_ADDR_KEEP_BITS = 14;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CHECK_CONFIG_RESET = 8'h80;
	localparam logic [15:0] FAULT_ADDR_RESET = 16'h8000;

	// ----------------------------------------------------------------
	// bus widths
	// ----------------------------------------------------------------
	localparam int WB_ADDR_W = 18;
	localparam int WB_DATA_W = 32;

	// outcome of one check-bit decode
	typedef struct packed {
		logic [7:0] data;
		logic fixed;
		logic fatal;
	} check_result_t;

	// configuration byte as held in flops
	typedef struct packed {
		logic enable;
		logic fatal_irq_enable;
		logic fixed_irq_enable;
		logic fatal_flag;
		logic fixed_flag;
	} check_config_t;

endpackage : ecc_monitor_pkg

// ==== design/memory_ecc_fault_monitor.sv ====
// check-bit supervisor for data sram and program fetch paths
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none

module memory_ecc_fault_monitor #(
	parameter int SRAM_DEPTH = 2048
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ecc_monitor_pkg::WB_ADDR_W-1:0] wb_adr_i,
	input wire logic [ecc_monitor_pkg::WB_DATA_W-1:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [ecc_monitor_pkg::WB_DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// cpu data sram port
	input wire logic sram_wr_i,
	input wire logic sram_rd_i,
	input wire logic [15:0] sram_addr_i,
	input wire logic [7:0] sram_wdata_i,
	output logic [7:0] sram_rdata_o,
	output logic sram_rvalid_o,
	// program fetch port
	input wire logic fetch_valid_i,
	input wire logic [15:0] fetch_addr_i,
	input wire logic [15:0] fetch_word_i,
	output logic [7:0] fetch_instr_o,
	output logic fetch_valid_o,
	// flash controller read port
	input wire logic fc_rd_i,
	input wire logic [15:0] fc_word_i,
	output logic [15:0] fc_rdata_o,
	output logic fc_check_error_o,
	// interrupts and reset handling
	output logic sram_fatal_irq_o,
	output logic sram_fixed_irq_o,
	output logic code_fatal_irq_o,
	output logic code_fixed_irq_o,
	output logic soft_reset_req_o,
	output logic reset_flag_clear_o
);

	localparam int SRAM_AW = $clog2(SRAM_DEPTH);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (SRAM_DEPTH < 2 || SRAM_DEPTH > 65536 || (1 << SRAM_AW) != SRAM_DEPTH)
	begin : g_bad_depth
		$error("SRAM_DEPTH must be a power of two from 2 to 65536");
	end
	// syndrome of each data bit; weight two or more keeps it apart from check bits
	localparam logic [3:0] BYTE_CODE [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC};
	localparam logic [2:0] NIB_CODE [4] = '{3'h3, 3'h5, 3'h6, 3'h7};

	// four hamming bits plus overall parity for one byte
	function automatic logic [4:0] byte_check(input logic [7:0] d);
		logic [3:0] s;
		s = 4'h0;
		for (int i = 0; i < 8; i++)
			s = s ^ (d[i] ? BYTE_CODE[i] : 4'h0);
		return {^{d, s}, s};
	endfunction : byte_check

	// three hamming bits plus overall parity for one nibble
	function automatic logic [3:0] nib_check(input logic [3:0] d);
		logic [2:0] s;
		s = 3'h0;
		for (int i = 0; i < 4; i++)
			s = s ^ (d[i] ? NIB_CODE[i] : 3'h0);
		return {^{d, s}, s};
	endfunction : nib_check

	// single error corrected, double error flagged
	function automatic ecc_monitor_pkg::check_result_t byte_decode(input logic [12:0] w);
		ecc_monitor_pkg::check_result_t r;
		logic [4:0] c;
		logic [3:0] s;
		logic p;
		c = byte_check(w[7:0]);
		s = c[3:0] ^ w[11:8];
		p = ^w;
		r.fixed = p;
		r.fatal = !p && (s != 4'h0);
		for (int i = 0; i < 8; i++)
			r.data[i] = w[i] ^ (p && s == BYTE_CODE[i]);
		return r;
	endfunction : byte_decode

	// one nibble with its four check bits
	function automatic logic [5:0] nib_decode(input logic [3:0] d, input logic [3:0] k);
		logic [3:0] c;
		logic [2:0] s;
		logic p;
		logic [3:0] o;
		c = nib_check(d);
		s = c[2:0] ^ k[2:0];
		p = ^{d, k};
		for (int i = 0; i < 4; i++)
			o[i] = d[i] ^ (p && s == NIB_CODE[i]);
		return {p, !p && (s != 3'h0), o};
	endfunction : nib_decode

	// word of flash: data low, checks high, nibble by nibble
	function automatic ecc_monitor_pkg::check_result_t word_decode(input logic [15:0] w);
		ecc_monitor_pkg::check_result_t r;
		logic [5:0] hi;
		logic [5:0] lo;
		hi = nib_decode(w[7:4], w[15:12]);
		lo = nib_decode(w[3:0], w[11:8]);
		r.data = {hi[3:0], lo[3:0]};
		r.fatal = hi[4] || lo[4];
		r.fixed = (hi[5] || lo[5]) && !r.fatal;
		return r;
	endfunction : word_decode

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [12:0] sram_mem [SRAM_DEPTH];
	ecc_monitor_pkg::check_config_t sram_cfg_reg, sram_cfg_next;
	ecc_monitor_pkg::check_config_t code_cfg_reg, code_cfg_next;
	logic [15:0] sram_fault_addr_reg, code_fault_addr_reg;
	logic [1:0] sram_cause_reg; // {fatal, fixed} flag that took the address
	logic check_error_reset_flag_reg, code_fatal_reset_enable_reg;
	logic [7:0] sram_rdata_reg, fetch_instr_reg;
	logic sram_rvalid_reg, fetch_valid_reg;
	logic [15:0] fc_rdata_reg;
	logic fc_err_reg, soft_req_reg, flag_clear_reg, ack_reg;
	logic [ecc_monitor_pkg::WB_DATA_W-1:0] dat_reg;

	// ----------------------------------------------------------------
	// wishbone decode
	// ----------------------------------------------------------------
	// ack one cycle after the strobe, write lands on the acked edge
	wire bus_req = wb_cyc_i && wb_stb_i;
	wire ack_next = bus_req && !ack_reg;
	wire wr_lane = bus_req && wb_we_i && ack_reg && wb_sel_i[0];
	wire [15:0] reg_idx = wb_adr_i[17:2];
	wire [7:0] wr_byte = wb_dat_i[7:0];
	wire [4:0] wr_fields = {wr_byte[ecc_monitor_pkg::CFG_ENABLE_BIT], // flop field order
		wr_byte[ecc_monitor_pkg::CFG_FATAL_IRQ_EN_BIT],
		wr_byte[ecc_monitor_pkg::CFG_FIXED_IRQ_EN_BIT],
		wr_byte[ecc_monitor_pkg::CFG_FATAL_FLAG_BIT], wr_byte[ecc_monitor_pkg::CFG_FIXED_FLAG_BIT]};
	wire wr_sram_cfg = wr_lane && reg_idx == ecc_monitor_pkg::SRAM_CHECK_CONFIG_IDX;
	wire wr_code_cfg = wr_lane && reg_idx == ecc_monitor_pkg::CODE_CHECK_CONFIG_IDX;
	wire wr_rst_ctl = wr_lane && reg_idx == ecc_monitor_pkg::RESET_CONTROL_IDX;
	wire flag_clear_cmd = wr_rst_ctl && wr_byte[ecc_monitor_pkg::RST_FLAG_CLEAR_BIT];

	// ----------------------------------------------------------------
	// sram path
	// ----------------------------------------------------------------
	// check bits written as zero when checking is off: toggling the mode spoils contents
	wire [SRAM_AW-1:0] sram_idx = sram_addr_i[SRAM_AW-1:0];
	wire [4:0] sram_chk = sram_cfg_reg.enable ? byte_check(sram_wdata_i) : 5'h00;
	wire [12:0] sram_word = sram_mem[sram_idx];
	wire ecc_monitor_pkg::check_result_t sram_res = byte_decode(sram_word);
	wire sram_checked = sram_rd_i && sram_cfg_reg.enable;
	wire sram_fatal_ev = sram_checked && sram_res.fatal;
	wire sram_fixed_ev = sram_checked && sram_res.fixed;
	wire [1:0] sram_flags = {sram_cfg_reg.fatal_flag, sram_cfg_reg.fixed_flag};
	wire sram_capture = (sram_fatal_ev || sram_fixed_ev) && ((sram_flags & sram_cause_reg) == 2'b00);
	// fetch and flash controller decode; flash reads never touch the flags
	wire ecc_monitor_pkg::check_result_t fetch_res = word_decode(fetch_word_i);
	wire code_fatal_ev = fetch_valid_i && fetch_res.fatal;
	wire code_fixed_ev = fetch_valid_i && fetch_res.fixed;
	wire code_capture = (code_fatal_ev || code_fixed_ev) && !check_error_reset_flag_reg;
	wire code_reset_ev = code_fatal_ev && code_fatal_reset_enable_reg;
	wire ecc_monitor_pkg::check_result_t fc_res = word_decode(fc_word_i);
	wire [15:0] fc_word_out = code_cfg_reg.enable ? {fc_word_i[15:8], fc_res.data} : fc_word_i;

	// ----------------------------------------------------------------
	// flag next values: set wins over a clear written in the same cycle
	// ----------------------------------------------------------------
	always_comb
	begin
		sram_cfg_next = sram_cfg_reg;
		code_cfg_next = code_cfg_reg;
		if (wr_sram_cfg)
			sram_cfg_next = wr_fields & (sram_cfg_reg | 5'h1C);
		if (wr_code_cfg)
			code_cfg_next = wr_fields & (code_cfg_reg | 5'h1C);
		sram_cfg_next.fatal_flag = sram_cfg_next.fatal_flag || sram_fatal_ev;
		sram_cfg_next.fixed_flag = sram_cfg_next.fixed_flag || sram_fixed_ev;
		code_cfg_next.fatal_flag = code_cfg_next.fatal_flag || code_fatal_ev;
		code_cfg_next.fixed_flag = code_cfg_next.fixed_flag || code_fixed_ev;
	end

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	// top two code address bits masked on read
	wire [15:0] code_addr_view = {2'b00, code_fault_addr_reg[ecc_monitor_pkg::CODE_ADDR_KEEP_BITS-1:0]};
	wire [7:0] rd_byte =
		reg_idx == ecc_monitor_pkg::SRAM_CHECK_CONFIG_IDX ? {sram_cfg_reg.enable, 1'b0,
			sram_cfg_reg.fatal_irq_enable, sram_cfg_reg.fixed_irq_enable, 2'b00,
			sram_cfg_reg.fatal_flag, sram_cfg_reg.fixed_flag} :
		reg_idx == ecc_monitor_pkg::CODE_CHECK_CONFIG_IDX ? {code_cfg_reg.enable, 1'b0,
			code_cfg_reg.fatal_irq_enable, code_cfg_reg.fixed_irq_enable, 2'b00,
			code_cfg_reg.fatal_flag, code_cfg_reg.fixed_flag} :
		reg_idx == ecc_monitor_pkg::SRAM_FAULT_ADDR_LOW_IDX ? sram_fault_addr_reg[7:0] :
		reg_idx == ecc_monitor_pkg::SRAM_FAULT_ADDR_HIGH_IDX ? sram_fault_addr_reg[15:8] :
		reg_idx == ecc_monitor_pkg::CODE_FAULT_ADDR_LOW_IDX ? code_addr_view[7:0] :
		reg_idx == ecc_monitor_pkg::CODE_FAULT_ADDR_HIGH_IDX ? code_addr_view[15:8] :
		reg_idx == ecc_monitor_pkg::RESET_CONTROL_IDX ?
			(8'(check_error_reset_flag_reg) << ecc_monitor_pkg::RST_CHECK_ERR_FLAG_BIT) :
		8'h00;

	// ----------------------------------------------------------------
	// bus slave flops
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end
		else
		begin
			ack_reg <= ack_next;
			if (ack_next)
				dat_reg <= {24'h000000, rd_byte};
		end
	end

	// ----------------------------------------------------------------
	// configuration and flags
	// ----------------------------------------------------------------
	// soft reset restores the config bytes but not addresses nor the reset flag
	always_ff @(posedge clk_i)
	begin
		if (rst_i || soft_rst_i)
		begin
			sram_cfg_reg <= ecc_monitor_pkg::check_config_t'(ecc_monitor_pkg::CHECK_CONFIG_RESET[7:3]);
			code_cfg_reg <= ecc_monitor_pkg::check_config_t'(ecc_monitor_pkg::CHECK_CONFIG_RESET[7:3]);
			code_fatal_reset_enable_reg <= 1'b0;
		end
		else
		begin
			sram_cfg_reg <= sram_cfg_next;
			code_cfg_reg <= code_cfg_next;
			if (wr_rst_ctl)
				code_fatal_reset_enable_reg <= wr_byte[ecc_monitor_pkg::RST_FATAL_RESET_EN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// fault addresses and reset cause flag
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sram_fault_addr_reg <= ecc_monitor_pkg::FAULT_ADDR_RESET;
			code_fault_addr_reg <= ecc_monitor_pkg::FAULT_ADDR_RESET;
			sram_cause_reg <= 2'b00;
			check_error_reset_flag_reg <= 1'b0;
		end
		else
		begin
			if (sram_capture)
			begin
				sram_fault_addr_reg <= sram_addr_i;
				sram_cause_reg <= {sram_fatal_ev, sram_fixed_ev};
			end
			if (code_capture)
				code_fault_addr_reg <= fetch_addr_i;
			if (code_reset_ev)
				check_error_reset_flag_reg <= 1'b1;
			else if (flag_clear_cmd)
				check_error_reset_flag_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// datapath outputs and pulses
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sram_rdata_reg <= 8'h00;
			sram_rvalid_reg <= 1'b0;
			fetch_instr_reg <= 8'h00;
			fetch_valid_reg <= 1'b0;
			fc_rdata_reg <= 16'h0000;
			fc_err_reg <= 1'b0;
			soft_req_reg <= 1'b0;
			flag_clear_reg <= 1'b0;
		end
		else
		begin
			sram_rvalid_reg <= sram_rd_i;
			if (sram_rd_i)
				sram_rdata_reg <= sram_cfg_reg.enable ? sram_res.data : sram_word[7:0];
			fetch_valid_reg <= fetch_valid_i;
			if (fetch_valid_i)
				fetch_instr_reg <= fetch_res.data;
			if (fc_rd_i)
			begin
				fc_rdata_reg <= fc_word_out;
				fc_err_reg <= fc_res.fatal || fc_res.fixed;
			end
			soft_req_reg <= code_reset_ev;
			flag_clear_reg <= flag_clear_cmd;
		end
	end

	// storage carries no reset; software fills it before use
	always_ff @(posedge clk_i)
	begin
		if (sram_wr_i)
			sram_mem[sram_idx] <= {sram_chk, sram_wdata_i};
	end

	// outputs straight from flops
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign sram_rdata_o = sram_rdata_reg;
	assign sram_rvalid_o = sram_rvalid_reg;
	assign fetch_instr_o = fetch_instr_reg;
	assign fetch_valid_o = fetch_valid_reg;
	assign fc_rdata_o = fc_rdata_reg;
	assign fc_check_error_o = fc_err_reg;
	assign soft_reset_req_o = soft_req_reg;
	assign reset_flag_clear_o = flag_clear_reg;
	// level irqs, one per flag and enable pair
	assign sram_fatal_irq_o = sram_cfg_reg.fatal_flag && sram_cfg_reg.fatal_irq_enable;
	assign sram_fixed_irq_o = sram_cfg_reg.fixed_flag && sram_cfg_reg.fixed_irq_enable;
	assign code_fatal_irq_o = code_cfg_reg.fatal_flag && code_cfg_reg.fatal_irq_enable;
	assign code_fixed_irq_o = code_cfg_reg.fixed_flag && code_cfg_reg.fixed_irq_enable;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sram_fatal_set_a: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
		sram_fatal_ev |=> sram_cfg_reg.fatal_flag) else $error("sram fatal flag not set");
	sram_fixed_set_a: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
		sram_fixed_ev |=> sram_cfg_reg.fixed_flag && sram_rvalid_o)
		else $error("sram fixed flag not set");
	sram_addr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		((sram_flags & sram_cause_reg) != 2'b00) |=> $stable(sram_fault_addr_reg))
		else $error("sram fault address overwritten");
	code_addr_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(code_fatal_ev || code_fixed_ev) && !check_error_reset_flag_reg
		|=> code_fault_addr_reg == $past(fetch_addr_i))
		else $error("code fault address not latched");
	code_addr_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
		check_error_reset_flag_reg |=> $stable(code_fault_addr_reg))
		else $error("code address changed while reset flag set");
	code_reset_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
		code_fatal_ev && code_fatal_reset_enable_reg
		|=> soft_reset_req_o && check_error_reset_flag_reg ##1 !soft_reset_req_o)
		else $error("fatal fetch did not request reset");
	flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		flag_clear_cmd && !code_reset_ev |=> !check_error_reset_flag_reg && reset_flag_clear_o)
		else $error("reset flag not cleared");
	flag_keep_a: assert property (@(posedge clk_i) disable iff (rst_i || soft_rst_i)
		wr_code_cfg && wr_byte[ecc_monitor_pkg::CFG_FIXED_FLAG_BIT] && code_cfg_reg.fixed_flag
		|=> code_cfg_reg.fixed_flag) else $error("writing one changed a flag");
	irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		code_fatal_irq_o == (code_cfg_reg.fatal_flag && code_cfg_reg.fatal_irq_enable))
		else $error("code fatal irq wrong");
	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack timing wrong");

endmodule : memory_ecc_fault_monitor

`default_nettype wire

// ==== verification/fetch_bus_model.sv ====
// cpu fetch bus model presenting check-coded flash words
`timescale 1ns/10ps
`default_nettype none
module fetch_bus_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] data_i,
	input wire logic [15:0] flip_i,
	output logic valid_o,
	output logic [15:0] addr_o,
	output logic [15:0] word_o
);
	// nibble code: syndromes 3,5,6,7 plus overall parity on top
	function automatic logic [3:0] nib(input logic [3:0] d);
		logic [2:0] k;
		k = (d[0] ? 3'h3 : 3'h0) ^ (d[1] ? 3'h5 : 3'h0) ^ (d[2] ? 3'h6 : 3'h0);
		k = k ^ (d[3] ? 3'h7 : 3'h0);
		return {^{d, k}, k};
	endfunction : nib

	initial
	begin
		valid_o = 1'b0;
		addr_o = 16'h0000;
		word_o = 16'h0000;
	end

	// ------------
	// word drive
	// ------------
	// idle bus shows inverted values so a stale word never passes
	always @(posedge clk_i)
	begin
		valid_o <= go_i;
		addr_o <= go_i ? addr_i : ~addr_o;
		word_o <= go_i ? {nib(data_i[7:4]), nib(data_i[3:0]), data_i} ^ flip_i : ~word_o;
	end
endmodule : fetch_bus_model
`default_nettype wire

// ==== verification/memory_ecc_fault_monitor_bench.sv ====
// self-checking bench for the memory check-bit fault monitor
`timescale 1ns/10ps
`default_nettype none
module memory_ecc_fault_monitor_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [17:0] adr = 18'h00000;
	logic [31:0] wdat = 32'h0;
	logic s_wr = 1'b0;
	logic s_rd = 1'b0;
	logic [15:0] s_a = 16'h0000;
	logic [7:0] s_d = 8'h00;
	logic go = 1'b0;
	logic [15:0] f_a = 16'h0000;
	logic [15:0] f_x = 16'h0000;
	logic [7:0] f_d = 8'h00;
	logic [31:0] rdat;
	logic ack, s_v, f_v, m_v, rst_req, clr_p, fc_e;
	logic [7:0] s_q, f_q;
	logic [15:0] m_a, m_w, fc_q;
	logic [3:0] irq;
	logic [8:0] es;
	logic [9:0] ef;
	logic [31:0] rs = 32'h2BB7;
	logic [31:0] q_wb[$];
	logic [8:0] q_s[$];
	logic [9:0] q_f[$];
	int n_errors = 0;
	int tests_run = 0;
	int n_req = 0;
	int n_clr = 0;

	always #4 clk_i = ~clk_i;

	fetch_bus_model mem (.clk_i(clk_i), .go_i(go), .addr_i(f_a), .data_i(f_d), .flip_i(f_x),
		.valid_o(m_v), .addr_o(m_a), .word_o(m_w));

	// the reset request loops back as the software-class reset, as the chip would do it
	memory_ecc_fault_monitor #(.SRAM_DEPTH(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.soft_rst_i(rst_req), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
		.sram_wr_i(s_wr), .sram_rd_i(s_rd), .sram_addr_i(s_a), .sram_wdata_i(s_d),
		.sram_rdata_o(s_q), .sram_rvalid_o(s_v), .fetch_valid_i(m_v), .fetch_addr_i(m_a),
		.fetch_word_i(m_w), .fetch_instr_o(f_q), .fetch_valid_o(f_v), .fc_rd_i(m_v),
		.fc_word_i(m_w), .fc_rdata_o(fc_q), .fc_check_error_o(fc_e), .sram_fatal_irq_o(irq[3]),
		.sram_fixed_irq_o(irq[2]), .code_fatal_irq_o(irq[1]), .code_fixed_irq_o(irq[0]),
		.soft_reset_req_o(rst_req), .reset_flag_clear_o(clr_p));

	// ------------
	// helpers
	// ------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : cmp

	// one classic cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [15:0] i, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= {24'h000000, d};
		@(posedge clk_i);
		while (ack !== 1'b1)
			@(posedge clk_i);
		cyc <= 1'b0;
	endtask : wb

	task automatic rd(input logic [15:0] i, input logic [7:0] e);
		q_wb.push_back({24'h000000, e});
		wb(1'b0, i, 8'h00);
	endtask : rd

	// k low: data of a fatal read is undefined, so it is not compared
	task automatic sram(input logic w, input logic [15:0] a, input logic [7:0] d, input logic k);
		if (!w)
			q_s.push_back({k, d});
		@(posedge clk_i);
		s_wr <= w;
		s_rd <= !w;
		s_a <= a;
		s_d <= d;
		@(posedge clk_i);
		s_wr <= 1'b0;
		s_rd <= 1'b0;
	endtask : sram

	task automatic fe(input logic [15:0] a, input logic [7:0] d, input logic [15:0] x, input logic k);
		q_f.push_back({x != 16'h0000, k, d});
		@(posedge clk_i);
		go <= 1'b1;
		f_a <= a;
		f_d <= d;
		f_x <= x;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : fe

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	// result watcher: oldest note against each result
	always @(posedge clk_i)
	begin
		if (ack === 1'b1 && !we)
			cmp("wb read", q_wb.pop_front(), rdat);
		if (s_v === 1'b1)
			es = q_s.pop_front();
		if (s_v === 1'b1 && es[8])
			cmp("sram data", {24'h000000, es[7:0]}, {24'h000000, s_q});
		if (f_v === 1'b1)
		begin
			ef = q_f.pop_front();
			cmp("flash error", {31'h0, ef[9]}, {31'h0, fc_e});
		end
		if (f_v === 1'b1 && ef[8])
		begin
			cmp("fetch byte", {24'h000000, ef[7:0]}, {24'h000000, f_q});
			cmp("flash read", {24'h000000, ef[7:0]}, {24'h000000, fc_q[7:0]});
		end
		if (rst_req === 1'b1)
			n_req++;
		if (clr_p === 1'b1)
			n_clr++;
	end

	initial
	begin
		repeat (5000) @(posedge clk_i);
		n_errors++;
		wrap_up();
	end

	// ------------
	// main sequence
	// ------------
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(16'hA02D, 8'h80);
		rd(16'hA00D, 8'h80);
		rd(16'hA02F, 8'h80);
		rd(16'hA00F, 8'h00);
		rd(16'hA011, 8'h00);
		$display("done reset values");
		for (int i = 0; i < 8; i++)
		begin
			rs = lfsr(rs);
			sram(1'b1, 16'(i), rs[7:0], 1'b1);
			sram(1'b0, 16'(i), rs[7:0], 1'b1);
		end
		// words stored unchecked become single and double faults
		wb(1'b1, 16'hA02D, 8'h30);
		sram(1'b1, 16'h0005, 8'h01, 1'b1);
		sram(1'b1, 16'h0006, 8'h03, 1'b1);
		wb(1'b1, 16'hA02D, 8'hB0);
		sram(1'b0, 16'h0005, 8'h00, 1'b1);
		sram(1'b0, 16'h0006, 8'h00, 1'b0);
		rd(16'hA02D, 8'hB3);
		cmp("sram irqs", 32'hC, {28'h0, irq});
		rd(16'hA02E, 8'h05);
		rd(16'hA02F, 8'h00);
		wb(1'b1, 16'hA02D, 8'hB3);
		rd(16'hA02D, 8'hB3);
		wb(1'b1, 16'hA02D, 8'h90);
		rd(16'hA02D, 8'h90);
		cmp("sram irqs", 32'h0, {28'h0, irq});
		// rewrite the corrected byte; the clean read after it sets no flag
		sram(1'b1, 16'h0005, 8'h00, 1'b1);
		sram(1'b0, 16'h0005, 8'h00, 1'b1);
		rd(16'hA02D, 8'h90);
		$display("done sram faults");
		rs = lfsr(rs);
		fe(16'h1234, rs[7:0], 16'h0000, 1'b1);
		wb(1'b1, 16'hA00D, 8'hB0);
		fe(16'hC123, 8'h5A, 16'h0004, 1'b1);
		rd(16'hA00E, 8'h23);
		rd(16'hA00F, 8'h01);
		cmp("code irqs", 32'h1, {28'h0, irq});
		fe(16'h0456, 8'hA5, 16'h0300, 1'b0);
		rd(16'hA00D, 8'hB3);
		rd(16'hA00E, 8'h56);
		cmp("code irqs", 32'h3, {28'h0, irq});
		wb(1'b1, 16'hA00D, 8'h80);
		rd(16'hA00D, 8'h80);
		wb(1'b1, 16'hA010, 8'h40);
		fe(16'h0789, 8'h11, 16'h0C00, 1'b0);
		rd(16'hA010, 8'h04);
		cmp("reset requests", 32'h1, n_req);
		rd(16'hA00D, 8'h80);
		fe(16'h0AAA, 8'h22, 16'h3000, 1'b0);
		cmp("reset requests", 32'h1, n_req);
		rd(16'hA00E, 8'h89);
		wb(1'b1, 16'hA010, 8'h10);
		rd(16'hA010, 8'h00);
		cmp("flag clears", 32'h1, n_clr);
		fe(16'h0BBB, 8'h33, 16'h0001, 1'b1);
		rd(16'hA00E, 8'hBB);
		$display("done code faults");
		wrap_up();
	end
endmodule : memory_ecc_fault_monitor_bench
`default_nettype wire
